// ===== hw/adc_status_select.sv
// Converter status, clock divider, reference and channel selection registers on APB
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "adc_stat_defs.svh"
module adc_status_select
  import adc_stat_pkg::*;
#(
  parameter int DEV_W = 16
)(
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              CE_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic [2:0]        STAGE_I,
  input  wire logic              ACC_OVF_I,
  input  wire logic              FILTER_OVF_I,
  input  wire logic              DEV_OVF_I,
  input  wire logic              OVF_CLEAR_I,
  input  wire logic              UPDATE_I,
  input  wire logic              DONE_CLEAR_I,
  input  wire logic [DEV_W-1:0]  DEVIATION_I,
  input  wire logic [DEV_W-1:0]  UPPER_LIMIT_I,
  input  wire logic [DEV_W-1:0]  LOWER_LIMIT_I,
  output logic                   CONV_CLK_O,
  output logic                   NEGATIVE_REFERENCE_SELECT_EXT_O,
  output logic      [1:0]        PREF_SEL_O,
  output logic      [2:0]        CHAN_KIND_O,
  output logic      [2:0]        CHAN_PORT_O,
  output logic      [2:0]        CHAN_PIN_O,
  output logic                   CHAN_CONNECT_O,
  output logic                   IRQ_O
);

  // ----------------------------------------------------------------
  // Channel decoding
  // ----------------------------------------------------------------
  function automatic input_kind_t kind_of(input logic [5:0] code);
    input_kind_t k;
    k = IN_NONE;
    if (code < 6'h23 || (code >= 6'h28 && code < 6'h30))
      k = IN_PORT;
    else if (code == 6'h3B)
      k = IN_GROUND;
    else if (code == 6'h3C)
      k = IN_TEMP;
    else if (code == 6'h3D)
      k = IN_DAC;
    else if (code == 6'h3E)
      k = IN_FIXED1;
    else if (code == 6'h3F)
      k = IN_FIXED2;
    return k;
  endfunction

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  conv_clk_if clk_link ();

  conv_clk_divider #(.DIV_W(`WID_DIVIDER)) u_div (
    .clk_i  (CLK_I),
    .srst_i (SRST_I),
    .ce_i   (CE_I),
    .link   (clk_link.div)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0]  divider;
  logic [5:0]  next_divider;
  logic        negative_reference_select;
  logic        next_negative_reference_select;
  logic [1:0]  pref;
  logic [1:0]  next_pref;
  logic [5:0]  channel;
  logic [5:0]  next_channel;
  logic        ovf;
  logic        next_ovf;
  logic        above;
  logic        next_above;
  logic        below;
  logic        next_below;
  logic        done;
  logic        next_done;
  logic [2:0]  stage;
  logic [2:0]  next_stage;
  logic [3:0]  ev_status;
  logic [3:0]  next_ev_status;
  logic [3:0]  ev_mask;
  logic [3:0]  next_ev_mask;
  logic        next_irq;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_conv_clk;
  logic [2:0]  next_kind;
  logic        wr_strobe;
  logic        access;
  logic        mapped;
  logic [3:0]  ev_set;
  logic [7:0]  status_byte;

  assign clk_link.divisor = divider;
  assign access      = PSEL_I && PENABLE_I;
  assign wr_strobe   = access && PREADY_O && PWRITE_I;
  assign status_byte = {ovf, above, below, done, 1'b0, stage};
  assign mapped      = PADDR_I[1:0] == 2'b00 && PADDR_I <= `OFS_EVENT_MASK;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ovf = ovf;
    if (OVF_CLEAR_I)
      next_ovf = 1'b0;
    if (ACC_OVF_I || FILTER_OVF_I || DEV_OVF_I)
      next_ovf = 1'b1;
    next_above = above;
    next_below = below;
    if (UPDATE_I)
    begin
      next_above = $signed(DEVIATION_I) > $signed(UPPER_LIMIT_I);
      next_below = $signed(DEVIATION_I) < $signed(LOWER_LIMIT_I);
    end
    next_done = done;
    if (DONE_CLEAR_I)
      next_done = 1'b0;
    if (UPDATE_I)
      next_done = 1'b1;
    // An unused code is shown as idle rather than passed on
    next_stage = (STAGE_I == 3'h4) ? STAGE_IDLE : STAGE_I;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      ovf   <= 1'b0;
      above <= 1'b0;
      below <= 1'b0;
      done  <= 1'b0;
      stage <= STAGE_IDLE;
    end
    else if (CE_I)
    begin
      ovf   <= next_ovf;
      above <= next_above;
      below <= next_below;
      done  <= next_done;
      stage <= next_stage;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and event registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_divider = divider;
    next_negative_reference_select    = negative_reference_select;
    next_pref    = pref;
    next_channel = channel;
    next_ev_mask = ev_mask;
    ev_set = {ACC_OVF_I || FILTER_OVF_I || DEV_OVF_I,
              UPDATE_I && !above && next_above,
              UPDATE_I && !below && next_below,
              UPDATE_I};
    next_ev_status = ev_status;
    // Status register writes fall through: no flag or stage bit is writable
    if (wr_strobe)
    begin
      unique case (PADDR_I)
        `OFS_CLOCK_DIVIDER:
          next_divider = PWDATA_I[5:0];
        `OFS_REFERENCE_SELECT:
        begin
          next_negative_reference_select = PWDATA_I[`POS_NEGATIVE_REFERENCE_SELECT];
          next_pref = PWDATA_I[1:0];
        end
        `OFS_CHANNEL_SELECT:
          next_channel = PWDATA_I[5:0];
        `OFS_EVENT_STATUS:
          next_ev_status = ev_status & ~PWDATA_I[3:0];
        `OFS_EVENT_MASK:
          next_ev_mask = PWDATA_I[3:0];
        default:
          next_ev_mask = ev_mask;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_ev_status = next_ev_status | ev_set;
    next_irq       = |(next_ev_status & next_ev_mask);
    next_conv_clk  = clk_link.level;
    next_kind      = kind_of(next_channel);
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      divider        <= `RST_DIVIDER;
      negative_reference_select           <= `RST_NEGATIVE_REFERENCE_SELECT;
      pref           <= `RST_PREF;
      channel        <= `RST_CHANNEL;
      ev_status      <= `RST_EVENTS;
      ev_mask        <= `RST_EVENTS;
      IRQ_O          <= 1'b0;
      CONV_CLK_O     <= 1'b0;
      NEGATIVE_REFERENCE_SELECT_EXT_O     <= `RST_NEGATIVE_REFERENCE_SELECT;
      PREF_SEL_O     <= `RST_PREF;
      CHAN_KIND_O    <= IN_PORT;
      CHAN_PORT_O    <= 3'h0;
      CHAN_PIN_O     <= 3'h0;
      CHAN_CONNECT_O <= 1'b1;
    end
    else if (CE_I)
    begin
      divider        <= next_divider;
      negative_reference_select           <= next_negative_reference_select;
      pref           <= next_pref;
      channel        <= next_channel;
      ev_status      <= next_ev_status;
      ev_mask        <= next_ev_mask;
      IRQ_O          <= next_irq;
      CONV_CLK_O     <= next_conv_clk;
      NEGATIVE_REFERENCE_SELECT_EXT_O     <= next_negative_reference_select;
      PREF_SEL_O     <= next_pref;
      CHAN_KIND_O    <= next_kind;
      CHAN_PORT_O    <= next_channel[5:3];
      CHAN_PIN_O     <= next_channel[2:0];
      CHAN_CONNECT_O <= next_kind != IN_NONE;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One wait state keeps read data and the answer straight out of flops
  always_comb
  begin
    next_pready  = access && !PREADY_O;
    next_pslverr = next_pready && !mapped;
    next_prdata  = PRDATA_O;
    if (next_pready)
    begin
      next_prdata = 32'h0000_0000;
      unique case (PADDR_I)
        `OFS_CONVERTER_STATUS:
          next_prdata[7:0] = status_byte;
        `OFS_CLOCK_DIVIDER:
          next_prdata[5:0] = divider;
        `OFS_REFERENCE_SELECT:
          next_prdata[4:0] = {negative_reference_select, 2'b00, pref};
        `OFS_CHANNEL_SELECT:
          next_prdata[5:0] = channel;
        `OFS_EVENT_STATUS:
          next_prdata[3:0] = ev_status;
        `OFS_EVENT_MASK:
          next_prdata[3:0] = ev_mask;
        default:
          next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else if (CE_I)
    begin
      PRDATA_O  <= next_prdata;
      PREADY_O  <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  overflow_sticky_a: assert property (CE_I && DEV_OVF_I |=> ovf)
    else $error("Overflow flag missed a deviation overflow");
  overflow_hold_a: assert property (CE_I && !OVF_CLEAR_I && ovf |=> ovf)
    else $error("Overflow flag dropped without clear");
  above_compare_a: assert property (CE_I && UPDATE_I |=>
      above == ($signed($past(DEVIATION_I)) > $signed($past(UPPER_LIMIT_I))))
    else $error("Above-upper flag disagrees with comparison");
  below_compare_a: assert property (CE_I && UPDATE_I |=>
      below == ($signed($past(DEVIATION_I)) < $signed($past(LOWER_LIMIT_I))))
    else $error("Below-lower flag disagrees with comparison");
  done_set_wins_a: assert property (CE_I && UPDATE_I && DONE_CLEAR_I |=> done)
    else $error("Done flag lost an update");
  stage_legal_a: assert property (stage != 3'h4)
    else $error("Unused stage code shown");
  status_readonly_a: assert property (CE_I && wr_strobe && PADDR_I == `OFS_CONVERTER_STATUS
      && !UPDATE_I && !DONE_CLEAR_I |=> done == $past(done))
    else $error("Status write changed done flag");
  reserved_zero_a: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h00_0000)
    else $error("Unimplemented read bits not zero");
  chan_open_a: assert property (CE_I && wr_strobe && PADDR_I == `OFS_CHANNEL_SELECT
      && PWDATA_I[5:0] == 6'h30 |=> !CHAN_CONNECT_O)
    else $error("Reserved channel left connected");
  negative_reference_select_follow_a: assert property (CE_I && wr_strobe && PADDR_I == `OFS_REFERENCE_SELECT
      |=> NEGATIVE_REFERENCE_SELECT_EXT_O == $past(PWDATA_I[4]))
    else $error("Negative reference not applied");
  answer_once_a: assert property (PREADY_O && CE_I |=> !PREADY_O)
    else $error("Answer held beyond one cycle");

  cover_irq_c: cover property (IRQ_O);
  cover_above_c: cover property (above && ovf);
  cover_stage_c: cover property (stage == STAGE_CONV2 ##1 stage == STAGE_IDLE);
  cover_slverr_c: cover property (PREADY_O && PSLVERR_O);

endmodule
`default_nettype wire

// ===== shared/adc_stat_defs.svh
// Register map, field positions, reset values and contract of the converter status block
//
// Contract
// - Overflow flag set by accumulator, filter or deviation
// - Above-upper flag when deviation exceeds upper limit
// - Below-lower flag when deviation under lower limit
// - Computation-done flag set and cleared by hardware
// - Stage code 3 bits, 100 never used
// - Stage code unreliable on RC clock, slow system
// - Conversion clock is system clock over 2*(field+1)
// - Negative reference external pin when select is one
// - Positive reference 11 fixed, 10 pin, 00 supply
// - Channel code selects ports, ground, temperature, DAC, references
// - Reserved channel codes leave converter input open
// - Unimplemented bits read zero, writes ignored
`ifndef ADC_STAT_DEFS_SVH
`define ADC_STAT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONVERTER_STATUS  8'h00
`define OFS_CLOCK_DIVIDER     8'h04
`define OFS_REFERENCE_SELECT  8'h08
`define OFS_CHANNEL_SELECT    8'h0C
`define OFS_EVENT_STATUS      8'h10
`define OFS_EVENT_MASK        8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_OVERFLOW     7
`define POS_ABOVE_UPPER  6
`define POS_BELOW_LOWER  5
`define POS_DONE         4
`define POS_NEGATIVE_REFERENCE_SELECT         4
`define WID_STAGE        3
`define WID_DIVIDER      6
`define WID_PREF         2
`define WID_CHANNEL      6
`define WID_EVENTS       4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_DIVIDER      6'h00
`define RST_NEGATIVE_REFERENCE_SELECT         1'b0
`define RST_PREF         2'h0
`define RST_CHANNEL      6'h00
`define RST_EVENTS       4'h0

`endif

// ===== shared/adc_stat_pkg.sv
// Types shared by the converter status block
`default_nettype none
package adc_stat_pkg;

  typedef enum logic [2:0] {
    STAGE_IDLE  = 3'h0,
    STAGE_PRE1  = 3'h1,
    STAGE_ACQ1  = 3'h2,
    STAGE_CONV1 = 3'h3,
    STAGE_PRE2  = 3'h5,
    STAGE_ACQ2  = 3'h6,
    STAGE_CONV2 = 3'h7
  } stage_t;

  typedef enum logic [1:0] {
    PREF_SUPPLY   = 2'h0,
    PREF_RESERVED = 2'h1,
    PREF_PIN      = 2'h2,
    PREF_FIXED    = 2'h3
  } pref_t;

  typedef enum logic [2:0] {
    IN_NONE   = 3'h0,
    IN_PORT   = 3'h1,
    IN_GROUND = 3'h2,
    IN_TEMP   = 3'h3,
    IN_DAC    = 3'h4,
    IN_FIXED1 = 3'h5,
    IN_FIXED2 = 3'h6
  } input_kind_t;

endpackage
`default_nettype wire

// ===== shared/conv_clk_if.sv
// Link between the register logic and the conversion clock divider
`timescale 1ns/10ps
`default_nettype none
interface conv_clk_if;
  logic [5:0] divisor;
  logic       level;
  logic       rise;

  modport ctrl (output divisor, input level, input rise);
  modport div  (input divisor, output level, output rise);
endinterface
`default_nettype wire

// ===== hw/conv_clk_divider.sv
// Conversion clock divider: system clock over 2*(divisor+1)
`timescale 1ns/10ps
`default_nettype none
module conv_clk_divider
  import adc_stat_pkg::*;
#(
  parameter int DIV_W = 6
)(
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  conv_clk_if.div   link
);

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic             level;
  logic             next_level;
  logic             rise;
  logic             next_rise;

  // Half period is divisor+1 system cycles; a divisor change acts at once on the running half period
  always_comb
  begin
    next_count = count + 1'b1;
    next_level = level;
    next_rise  = 1'b0;
    if (count >= link.divisor)
    begin
      next_count = '0;
      next_level = ~level;
      next_rise  = ~level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count <= '0;
      level <= 1'b0;
      rise  <= 1'b0;
    end
    else if (ce_i)
    begin
      count <= next_count;
      level <= next_level;
      rise  <= next_rise;
    end
  end

  assign link.level = level;
  assign link.rise  = rise;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  half_period_a: assert property (ce_i && count == link.divisor |=> level != $past(level))
    else $error("Divider did not toggle at terminal count");
  hold_level_a: assert property (ce_i && count < link.divisor |=> level == $past(level))
    else $error("Divider toggled before terminal count");
  cover_toggle_c: cover property (ce_i && count == link.divisor && link.divisor == 6'h3F);

endmodule
`default_nettype wire

// ===== testbench/adc_status_and_input_select_tb.sv
// Self-checking testbench of the converter status and input selection block
`timescale 1ns/10ps
`default_nettype none
`include "adc_stat_defs.svh"
module adc_status_and_input_select_tb
  import adc_stat_pkg::*;
;
  logic        clk, srst, psel, penable, pwrite, acc_ovf, flt_ovf, dev_ovf, ovf_clr, upd, done_clr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, conv_clk, negative_reference_select, chan_con, irq, er, ce;
  logic [1:0]  pref;
  logic [2:0]  stage, kind, cport, cpin;
  logic [15:0] dev, upl, lol;
  logic [31:0] seed;
  int          error_cnt, cmp_count, p;

  adc_status_select adc_status_select_i (.CLK_I(clk), .SRST_I(srst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .STAGE_I(stage), .ACC_OVF_I(acc_ovf), .FILTER_OVF_I(flt_ovf), .DEV_OVF_I(dev_ovf),
    .OVF_CLEAR_I(ovf_clr), .UPDATE_I(upd), .DONE_CLEAR_I(done_clr), .DEVIATION_I(dev),
    .UPPER_LIMIT_I(upl), .LOWER_LIMIT_I(lol), .CONV_CLK_O(conv_clk), .NEGATIVE_REFERENCE_SELECT_EXT_O(negative_reference_select),
    .PREF_SEL_O(pref), .CHAN_KIND_O(kind), .CHAN_PORT_O(cport), .CHAN_PIN_O(cpin),
    .CHAN_CONNECT_O(chan_con), .IRQ_O(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected {connect, kind} of a channel code
  function automatic logic [3:0] chan_exp(input logic [5:0] c);
    if (c <= 6'h22 || (c >= 6'h28 && c <= 6'h2F))
      return {1'b1, IN_PORT};
    case (c)
      6'h3B: return {1'b1, IN_GROUND};
      6'h3C: return {1'b1, IN_TEMP};
      6'h3D: return {1'b1, IN_DAC};
      6'h3E: return {1'b1, IN_FIXED1};
      6'h3F: return {1'b1, IN_FIXED2};
      default: return {1'b0, IN_NONE};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for the answer under a bounded count
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      check(32'h0000_0000, 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One-cycle pulse on the event inputs: acc, filter, dev, ovf clear, update, done clear
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    {acc_ovf, flt_ovf, dev_ovf, ovf_clr, upd, done_clr} <= m;
    @(posedge clk);
    {acc_ovf, flt_ovf, dev_ovf, ovf_clr, upd, done_clr} <= 6'h00;
  endtask

  // Cycles spent until the conversion clock shows level v
  task automatic wait_lvl(input logic v, inout int c);
    int n;
    n = 0;
    while (conv_clk !== v && n < 300)
    begin
      @(posedge clk);
      n++;
      c++;
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, acc_ovf, flt_ovf, dev_ovf, ovf_clr, upd, done_clr} = '0;
    paddr = 8'h00; pwdata = 32'h0000_0000; stage = 3'h0;
    dev = 16'h0000; upl = 16'h0000; lol = 16'h0000;
    seed = 32'h0000_814D; error_cnt = 0; cmp_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // Reset values and unimplemented bits
    apb(0, `OFS_CONVERTER_STATUS, 32'h0); check(rd, 32'h0);
    apb(0, `OFS_CLOCK_DIVIDER, 32'h0); check(rd, 32'h0);
    apb(0, `OFS_REFERENCE_SELECT, 32'h0); check(rd, 32'h0);
    apb(0, `OFS_CHANNEL_SELECT, 32'h0); check(rd, 32'h0);
    check({chan_con, kind}, {1'b1, IN_PORT});
    apb(1, `OFS_CLOCK_DIVIDER, 32'hFFFF_FFFF); apb(0, `OFS_CLOCK_DIVIDER, 32'h0);
    check(rd, 32'h0000_003F);
    apb(1, `OFS_REFERENCE_SELECT, 32'hFFFF_FFFF); apb(0, `OFS_REFERENCE_SELECT, 32'h0);
    check(rd, 32'h0000_0013);
    apb(0, 8'h18, 32'h0); check(er, 1'b1);
    check(rd, 32'h0);
    apb(0, 8'h05, 32'h0); check(er, 1'b1);
    $display("test reset_and_map done");
    // Divider period over boundary and random codes
    for (int i = 0; i < 4; i++)
    begin
      logic [5:0] d;
      seed = lfsr(seed);
      d = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : seed[5:0];
      apb(1, `OFS_CLOCK_DIVIDER, {26'h0, d});
      // Two rising edges pass first: the half running at the write compares a count begun under the old code to the new one
      repeat (2)
      begin
        wait_lvl(1'b0, p);
        wait_lvl(1'b1, p);
      end
      p = 0; wait_lvl(1'b0, p); wait_lvl(1'b1, p);
      check(p, 2 * (d + 1));
    end
    $display("test divider done");
    // Reference selection, every code
    for (int i = 0; i < 8; i++)
    begin
      apb(1, `OFS_REFERENCE_SELECT, {27'h0, i[2], 2'h0, i[1:0]});
      apb(0, `OFS_REFERENCE_SELECT, 32'h0);
      check({negative_reference_select, pref}, i[2:0]);
    end
    $display("test reference done");
    // Every channel code, upper bits set to show they are dropped
    for (int i = 0; i < 64; i++)
    begin
      apb(1, `OFS_CHANNEL_SELECT, {26'h3FF_FFFF, i[5:0]});
      apb(0, `OFS_CHANNEL_SELECT, 32'h0);
      check(rd, {26'h0, i[5:0]});
      check({chan_con, kind}, chan_exp(i[5:0]));
      check({cport, cpin}, i[5:0]);
    end
    $display("test channel done");
    // Stage code, including the unused code
    for (int i = 0; i < 8; i++)
    begin
      stage <= i[2:0];
      apb(0, `OFS_CONVERTER_STATUS, 32'h0);
      check(rd[3:0], (i == 4) ? 4'h0 : {1'b0, i[2:0]});
      apb(1, `OFS_CONVERTER_STATUS, 32'h0000_0000);
    end
    stage <= 3'h0;
    $display("test stage done");
    // Overflow from each source, then cleared
    for (int i = 0; i < 3; i++)
    begin
      pulse(6'h20 >> i);
      apb(0, `OFS_CONVERTER_STATUS, 32'h0); check(rd[7], 1'b1);
      apb(1, `OFS_CONVERTER_STATUS, 32'h0); apb(0, `OFS_CONVERTER_STATUS, 32'h0);
      check(rd[7], 1'b1);
      pulse(6'h04);
      apb(0, `OFS_CONVERTER_STATUS, 32'h0); check(rd[7], 1'b0);
    end
    $display("test overflow done");
    // Limits compared as signed values, equal values as corners
    for (int i = 0; i < 10; i++)
    begin
      logic [15:0] dv, up, lo;
      seed = lfsr(seed); dv = seed[15:0];
      seed = lfsr(seed); up = (i == 0) ? dv : seed[15:0];
      seed = lfsr(seed); lo = (i == 1) ? dv : seed[15:0];
      @(posedge clk);
      dev <= dv; upl <= up; lol <= lo;
      pulse(6'h02);
      apb(0, `OFS_CONVERTER_STATUS, 32'h0);
      check(rd[6], $signed(dv) > $signed(up));
      check(rd[5], $signed(dv) < $signed(lo));
      check(rd[4], 1'b1);
      pulse(6'h01);
      apb(0, `OFS_CONVERTER_STATUS, 32'h0); check(rd[4], 1'b0);
    end
    $display("test compare done");
    // Clock enable low freezes the flags: an update in that cycle is lost
    @(posedge clk);
    ce <= 1'b0;
    pulse(6'h02);
    ce <= 1'b1;
    apb(0, `OFS_CONVERTER_STATUS, 32'h0); check(rd[4], 1'b0);
    $display("test enable done");
    // Interrupt raised, masked and cleared
    apb(1, `OFS_EVENT_STATUS, 32'h0000_000F);
    apb(1, `OFS_EVENT_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    pulse(6'h02);
    apb(0, `OFS_EVENT_STATUS, 32'h0); check(rd[0], 1'b1);
    check(irq, 1'b1);
    apb(1, `OFS_EVENT_MASK, 32'h0); repeat (2) @(posedge clk); check(irq, 1'b0);
    apb(1, `OFS_EVENT_MASK, 32'h1); repeat (2) @(posedge clk); check(irq, 1'b1);
    apb(1, `OFS_EVENT_STATUS, 32'h1); repeat (2) @(posedge clk); check(irq, 1'b0);
    apb(0, `OFS_EVENT_STATUS, 32'h0); check(rd[0], 1'b0);
    $display("test interrupt done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
